// >>> sgmii_ctrl_status_regs.svh
// Register map constants for the SGMII management register bank.
// Assumes MDIO clause 22 framing and 16-bit registers.
`ifndef SGMII_CTRL_STATUS_REGS_SVH
`define SGMII_CTRL_STATUS_REGS_SVH

// ==========================================================================
// Register numbers and MDIO framing
`define MDIO_REG_CTRL      5'h00
`define MDIO_REG_STAT      5'h01
`define MDIO_OP_WRITE      2'b01
`define MDIO_OP_READ       2'b10
`define MDIO_OP_LAST       5'h01
`define MDIO_ADDR_LAST     5'h09
`define MDIO_TURN_LAST     5'h01
`define MDIO_DATA_LAST     5'h0f

// ==========================================================================
// Control register field positions
`define CTRL_PDOWN_BIT     11
`define CTRL_ISOLATE_BIT   10
`define CTRL_RESTART_BIT   9
`define CTRL_DUPLEX_BIT    8
`define CTRL_COLTEST_BIT   7
`define CTRL_SPEEDMSB_BIT  6
`define CTRL_UNIDIR_BIT    5

// ==========================================================================
// Status register field positions
`define STAT_EXTSTAT_BIT   8
`define STAT_UNIABIL_BIT   7
`define STAT_PRESUP_BIT    6
`define STAT_ANCOMP_BIT    5
`define STAT_RFAULT_BIT    4
`define STAT_ANABIL_BIT    3
`define STAT_LINK_BIT      2
`define STAT_JABBER_BIT    1
`define STAT_EXTCAP_BIT    0

// ==========================================================================
// Reset and fixed values
`define CTRL_PDOWN_RST     1'b0
`define CTRL_ISOLATE_RST   1'b1
`define CTRL_SPEEDMSB_RST  1'b1
`define CTRL_UNIDIR_RST    1'b0
`define CTRL_DUPLEX_VAL    1'b1
`define CTRL_COLTEST_VAL   1'b0
`define STAT_EXTSTAT_VAL   1'b1
`define STAT_UNIABIL_VAL   1'b1
`define STAT_PRESUP_VAL    1'b1
`define STAT_ANCOMP_VAL    1'b0
`define STAT_RFAULT_VAL    1'b0
`define STAT_ANABIL_VAL    1'b0
`define STAT_LINK_RST      1'b0
`define REG_ZERO           16'h0000

`endif

// >>> sgmii_pkg.sv
// Types shared by the SGMII management register bank.
// Assumes the constants header supplies all numbers.
package sgmii_pkg;

  // ========================================================================
  // Build options
  typedef enum logic {BUILD_SERDES, BUILD_TBI} phy_build_t;

  // ========================================================================
  // MDIO receive states
  typedef enum logic [2:0] {
    S_IDLE, S_START, S_OP, S_ADDR, S_TURN, S_DATA
  } mdio_state_t;

  // ========================================================================
  // Bundled signals
  typedef struct packed {
    logic powerDown;
    logic isolate;
    logic speedMsb;
    logic unidir;
  } ctrl_bits_t;

  typedef struct packed {
    logic syncOk;
    logic xcvrResetDone;
  } link_in_t;

  typedef struct packed {
    logic        stb;
    logic [4:0]  regAddr;
    logic [15:0] data;
  } reg_write_t;

endpackage

// >>> pin_sync.sv
// Three-stage pin synchroniser with agreement filter.
// Assumes the pin is asynchronous to clk.
`timescale 1ns/1ps
module pin_sync #(
  parameter logic INIT = 1'b0
) (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic pinIn,
  output logic      level
);

  logic stage1;
  logic stage2;
  logic stage3;

  // ========================================================================
  // Shift chain
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stage1 <= INIT;
      stage2 <= INIT;
      stage3 <= INIT;
    end else begin
      stage1 <= pinIn;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // ========================================================================
  // Accept a change once the last two stages agree
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      level <= INIT;
    end else if (stage2 == stage3) begin
      level <= stage3;
    end
  end

endmodule // pin_sync

// >>> sgmii_ctrl_status_regs.sv
// SGMII control and status register bank reached over MDIO.
// Assumes link inputs, soft reset and clock lock are on clk;
// mdc and mdioIn are asynchronous pins.
`timescale 1ns/1ps
`include "sgmii_ctrl_status_regs.svh"

module sgmii_ctrl_status_regs #(
  parameter sgmii_pkg::phy_build_t PHY_BUILD         = sgmii_pkg::BUILD_SERDES,
  parameter logic                  EMBEDDED_MAC_MODE = 1'b0
) (
  input  wire logic                 clk,
  input  wire logic                 reset_n,
  input  wire logic                 softReset,
  input  wire logic                 clkLocked,
  input  wire logic [4:0]           phyAddr,
  input  wire logic                 mdc,
  input  wire logic                 mdioIn,
  output logic                      mdioOut,
  output logic                      mdioOe,
  input  wire sgmii_pkg::link_in_t  linkIn,
  output sgmii_pkg::ctrl_bits_t     ctrlOut,
  output logic                      serdesPowerDown,
  output logic                      anRestart,
  output logic                      linkStatus
);

  // ========================================================================
  // Declarations
  logic                   mdcLevel;
  logic                   mdcLevelDly_r;
  logic                   mdioLevel;
  logic                   mdcRise;
  logic                   coreRst;
  logic                   linkUp;

  sgmii_pkg::mdio_state_t state_r;
  logic [4:0]             bitCnt_r;
  logic [1:0]             opcode_r;
  logic [9:0]             addrShift_r;
  logic [9:0]             addrFull;
  logic                   isRead_r;
  logic                   hit_r;
  logic [4:0]             regAddr_r;
  logic [15:0]            shift_r;
  logic                   statRead;
  logic                   frameHit;
  logic                   frameRead;

  sgmii_pkg::ctrl_bits_t  ctrl_r;
  sgmii_pkg::reg_write_t  wr_r;
  logic                   latchedLink_r;
  logic [15:0]            rdCtrl;
  logic [15:0]            rdStat;
  logic [15:0]            rdData;

  // ========================================================================
  // Pin synchronisers
  pin_sync #(
    .INIT (1'b0)
  ) u_mdc_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .pinIn   (mdc),
    .level   (mdcLevel)
  );

  pin_sync #(
    .INIT (1'b1)
  ) u_mdio_sync (
    .clk     (clk),
    .reset_n (reset_n),
    .pinIn   (mdioIn),
    .level   (mdioLevel)
  );

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mdcLevelDly_r <= 1'b0;
    end else begin
      mdcLevelDly_r <= mdcLevel;
    end
  end

  assign mdcRise = mdcLevel & ~mdcLevelDly_r;

  // ========================================================================
  // Core reset sources
  assign coreRst = softReset | ~clkLocked;
  assign linkUp  = linkIn.syncOk & linkIn.xcvrResetDone;

  // ========================================================================
  // Frame decode helpers
  assign addrFull  = {addrShift_r[8:0], mdioLevel};
  assign frameHit  = (addrFull[9:5] == phyAddr) &&
                     ((opcode_r == `MDIO_OP_READ) || (opcode_r == `MDIO_OP_WRITE));
  assign frameRead = (opcode_r == `MDIO_OP_READ);
  assign statRead  = mdcRise && (state_r == sgmii_pkg::S_ADDR) &&
                     (bitCnt_r == `MDIO_ADDR_LAST) && frameHit && frameRead &&
                     (addrFull[4:0] == `MDIO_REG_STAT);

  // ========================================================================
  // Read data composition
  always_comb begin
    rdCtrl                      = `REG_ZERO;
    rdCtrl[`CTRL_PDOWN_BIT]     = ctrl_r.powerDown;
    rdCtrl[`CTRL_ISOLATE_BIT]   = ctrl_r.isolate;
    rdCtrl[`CTRL_RESTART_BIT]   = 1'b0;
    rdCtrl[`CTRL_DUPLEX_BIT]    = `CTRL_DUPLEX_VAL;
    rdCtrl[`CTRL_COLTEST_BIT]   = `CTRL_COLTEST_VAL;
    rdCtrl[`CTRL_SPEEDMSB_BIT]  = ctrl_r.speedMsb;
    rdCtrl[`CTRL_UNIDIR_BIT]    = ctrl_r.unidir;
  end

  always_comb begin
    rdStat                      = `REG_ZERO;
    rdStat[`STAT_EXTSTAT_BIT]   = `STAT_EXTSTAT_VAL;
    rdStat[`STAT_UNIABIL_BIT]   = `STAT_UNIABIL_VAL;
    rdStat[`STAT_PRESUP_BIT]    = `STAT_PRESUP_VAL;
    rdStat[`STAT_ANCOMP_BIT]    = `STAT_ANCOMP_VAL;
    rdStat[`STAT_RFAULT_BIT]    = `STAT_RFAULT_VAL;
    rdStat[`STAT_ANABIL_BIT]    = `STAT_ANABIL_VAL;
    rdStat[`STAT_LINK_BIT]      = latchedLink_r;
  end

  always_comb begin
    case (addrFull[4:0])
      `MDIO_REG_CTRL: rdData = rdCtrl;
      `MDIO_REG_STAT: rdData = rdStat;
      default:        rdData = `REG_ZERO;
    endcase
  end

  // ========================================================================
  // MDIO frame receiver
  // Preamble is optional: a zero then a one on an idle line starts a frame.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r     <= sgmii_pkg::S_IDLE;
      bitCnt_r    <= 5'h00;
      opcode_r    <= 2'b00;
      addrShift_r <= 10'h000;
      isRead_r    <= 1'b0;
      hit_r       <= 1'b0;
      regAddr_r   <= 5'h00;
    end else if (coreRst) begin
      state_r     <= sgmii_pkg::S_IDLE;
      bitCnt_r    <= 5'h00;
      hit_r       <= 1'b0;
    end else if (mdcRise) begin
      case (state_r)
        sgmii_pkg::S_IDLE: begin
          if (!mdioLevel) begin
            state_r <= sgmii_pkg::S_START;
          end
        end
        sgmii_pkg::S_START: begin
          bitCnt_r <= 5'h00;
          state_r  <= mdioLevel ? sgmii_pkg::S_OP : sgmii_pkg::S_IDLE;
        end
        sgmii_pkg::S_OP: begin
          opcode_r <= {opcode_r[0], mdioLevel};
          if (bitCnt_r == `MDIO_OP_LAST) begin
            bitCnt_r <= 5'h00;
            state_r  <= sgmii_pkg::S_ADDR;
          end else begin
            bitCnt_r <= bitCnt_r + 5'h01;
          end
        end
        sgmii_pkg::S_ADDR: begin
          addrShift_r <= addrFull;
          if (bitCnt_r == `MDIO_ADDR_LAST) begin
            bitCnt_r  <= 5'h00;
            hit_r     <= frameHit;
            isRead_r  <= frameRead;
            regAddr_r <= addrFull[4:0];
            state_r   <= sgmii_pkg::S_TURN;
          end else begin
            bitCnt_r <= bitCnt_r + 5'h01;
          end
        end
        sgmii_pkg::S_TURN: begin
          if (bitCnt_r == `MDIO_TURN_LAST) begin
            bitCnt_r <= 5'h00;
            state_r  <= sgmii_pkg::S_DATA;
          end else begin
            bitCnt_r <= bitCnt_r + 5'h01;
          end
        end
        sgmii_pkg::S_DATA: begin
          if (bitCnt_r == `MDIO_DATA_LAST) begin
            bitCnt_r <= 5'h00;
            state_r  <= sgmii_pkg::S_IDLE;
          end else begin
            bitCnt_r <= bitCnt_r + 5'h01;
          end
        end
        default: begin
          state_r <= sgmii_pkg::S_IDLE;
        end
      endcase
    end
  end

  // ========================================================================
  // Data shifter: loads read data, collects write data
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      shift_r <= `REG_ZERO;
    end else if (mdcRise) begin
      if (state_r == sgmii_pkg::S_ADDR && bitCnt_r == `MDIO_ADDR_LAST) begin
        shift_r <= rdData;
      end else if (state_r == sgmii_pkg::S_TURN && bitCnt_r == `MDIO_TURN_LAST &&
                   isRead_r) begin
        shift_r <= {shift_r[14:0], 1'b0};
      end else if (state_r == sgmii_pkg::S_DATA) begin
        shift_r <= {shift_r[14:0], mdioLevel};
      end
    end
  end

  // ========================================================================
  // MDIO driver: turnaround zero then sixteen data bits, MSB first
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mdioOut <= 1'b1;
      mdioOe  <= 1'b0;
    end else if (coreRst) begin
      mdioOut <= 1'b1;
      mdioOe  <= 1'b0;
    end else if (mdcRise && hit_r && isRead_r) begin
      if (state_r == sgmii_pkg::S_TURN && bitCnt_r != `MDIO_TURN_LAST) begin
        mdioOut <= 1'b0;
        mdioOe  <= 1'b1;
      end else if (state_r == sgmii_pkg::S_TURN) begin
        mdioOut <= shift_r[15];
      end else if (state_r == sgmii_pkg::S_DATA && bitCnt_r != `MDIO_DATA_LAST) begin
        mdioOut <= shift_r[15];
      end else if (state_r == sgmii_pkg::S_DATA) begin
        mdioOut <= 1'b1;
        mdioOe  <= 1'b0;
      end
    end
  end

  // ========================================================================
  // Write strobe at the last data bit of an addressed write
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_r <= '0;
    end else begin
      wr_r.stb <= mdcRise && hit_r && !isRead_r && !coreRst &&
                  state_r == sgmii_pkg::S_DATA && bitCnt_r == `MDIO_DATA_LAST;
      if (mdcRise && state_r == sgmii_pkg::S_DATA) begin
        wr_r.regAddr <= regAddr_r;
        wr_r.data    <= {shift_r[14:0], mdioLevel};
      end
    end
  end

  // ========================================================================
  // Control register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_r.powerDown <= `CTRL_PDOWN_RST;
      ctrl_r.isolate   <= `CTRL_ISOLATE_RST;
      ctrl_r.speedMsb  <= `CTRL_SPEEDMSB_RST;
      ctrl_r.unidir    <= `CTRL_UNIDIR_RST;
    end else if (coreRst) begin
      ctrl_r.powerDown <= `CTRL_PDOWN_RST;
      ctrl_r.isolate   <= `CTRL_ISOLATE_RST;
      ctrl_r.speedMsb  <= `CTRL_SPEEDMSB_RST;
      ctrl_r.unidir    <= `CTRL_UNIDIR_RST;
    end else if (wr_r.stb && wr_r.regAddr == `MDIO_REG_CTRL) begin
      ctrl_r.powerDown <= ctrl_r.powerDown | wr_r.data[`CTRL_PDOWN_BIT];
      ctrl_r.isolate   <= wr_r.data[`CTRL_ISOLATE_BIT];
      ctrl_r.unidir    <= wr_r.data[`CTRL_UNIDIR_BIT];
      if (EMBEDDED_MAC_MODE) begin
        ctrl_r.speedMsb <= wr_r.data[`CTRL_SPEEDMSB_BIT];
      end
    end
  end

  // ========================================================================
  // Restart request pulse; the stored bit never holds a one
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      anRestart <= 1'b0;
    end else begin
      anRestart <= !coreRst && wr_r.stb && wr_r.regAddr == `MDIO_REG_CTRL &&
                   wr_r.data[`CTRL_RESTART_BIT];
    end
  end

  // ========================================================================
  // Latched-low link status
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      latchedLink_r <= `STAT_LINK_RST;
    end else if (coreRst) begin
      latchedLink_r <= `STAT_LINK_RST;
    end else if (statRead) begin
      latchedLink_r <= linkUp;
    end else if (!linkUp) begin
      latchedLink_r <= 1'b0;
    end
  end

  // ========================================================================
  // Registered outputs to the datapath
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ctrlOut.powerDown <= `CTRL_PDOWN_RST;
      ctrlOut.isolate   <= `CTRL_ISOLATE_RST;
      ctrlOut.speedMsb  <= `CTRL_SPEEDMSB_RST;
      ctrlOut.unidir    <= `CTRL_UNIDIR_RST;
      serdesPowerDown   <= 1'b0;
      linkStatus        <= `STAT_LINK_RST;
    end else begin
      ctrlOut.powerDown <= ctrl_r.powerDown;
      ctrlOut.isolate   <= ctrl_r.isolate;
      ctrlOut.speedMsb  <= ctrl_r.speedMsb;
      ctrlOut.unidir    <= ctrl_r.unidir;
      serdesPowerDown   <= ctrl_r.powerDown &&
                           (PHY_BUILD == sgmii_pkg::BUILD_SERDES);
      linkStatus        <= latchedLink_r;
    end
  end

endmodule // sgmii_ctrl_status_regs

// >>> sgmii_ctrl_status_regs_chk.sv
// Port checker for the SGMII management register bank.
// Assumes it is bound to every instance of the bank.
`timescale 1ns/1ps
module sgmii_ctrl_status_regs_chk #(
  parameter sgmii_pkg::phy_build_t PHY_BUILD         = sgmii_pkg::BUILD_SERDES,
  parameter logic                  EMBEDDED_MAC_MODE = 1'b0
) (
  input wire logic                clk,
  input wire logic                reset_n,
  input wire logic                softReset,
  input wire logic                clkLocked,
  input wire logic                mdioOut,
  input wire logic                mdioOe,
  input wire sgmii_pkg::link_in_t linkIn,
  input wire sgmii_pkg::ctrl_bits_t ctrlOut,
  input wire logic                serdesPowerDown,
  input wire logic                anRestart,
  input wire logic                linkStatus
);
  // ========================================================================
  // Helpers
  logic [2:0] goodHist_r;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) goodHist_r <= 3'h0;
    else goodHist_r <= {goodHist_r[1:0], linkIn.syncOk & linkIn.xcvrResetDone};
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence resetReq;
    softReset || !clkLocked;
  endsequence
  sequence linkLost;
    !linkIn.syncOk [*3];
  endsequence
  sequence steadyDown;
    (ctrlOut.powerDown && !softReset && clkLocked) [*3];
  endsequence
  // ========================================================================
  // Assertions
  soft_defaults_a: assert property (resetReq |-> ##[1:3] ctrlOut == 4'h6)
    else $error("control bits not at defaults after core reset");
  reset_release_a: assert property (resetReq |-> ##[1:2] !mdioOe)
    else $error("MDIO still driven after core reset");
  pdown_sticky_a: assert property ($fell(ctrlOut.powerDown) |->
    $past(softReset) || $past(softReset, 2) || !$past(clkLocked) || !$past(clkLocked, 2))
    else $error("power-down cleared without core reset");
  serdes_pd_a: assert property (PHY_BUILD == sgmii_pkg::BUILD_SERDES ##0 steadyDown
    |-> serdesPowerDown) else $error("transceiver not in low power");
  tbi_pd_a: assert property (PHY_BUILD == sgmii_pkg::BUILD_TBI |-> !serdesPowerDown)
    else $error("low-power request in ten-bit build");
  speed_fixed_a: assert property (!EMBEDDED_MAC_MODE |-> ctrlOut.speedMsb)
    else $error("speed upper bit not one");
  restart_pulse_a: assert property (anRestart |=> !anRestart)
    else $error("restart request longer than one cycle");
  link_latch_a: assert property (linkLost |-> !linkStatus)
    else $error("link status high while link down");
  link_cause_a: assert property ($rose(linkStatus) |-> goodHist_r != 3'h0)
    else $error("link status rose without a valid link");
  turn_drive_a: assert property ($rose(mdioOe) |-> !mdioOut ##1 mdioOe [*7])
    else $error("turnaround drive wrong");
endmodule // sgmii_ctrl_status_regs_chk

bind sgmii_ctrl_status_regs sgmii_ctrl_status_regs_chk #(
  .PHY_BUILD(PHY_BUILD), .EMBEDDED_MAC_MODE(EMBEDDED_MAC_MODE)
) chk (
  .clk(clk), .reset_n(reset_n), .softReset(softReset), .clkLocked(clkLocked),
  .mdioOut(mdioOut), .mdioOe(mdioOe), .linkIn(linkIn), .ctrlOut(ctrlOut),
  .serdesPowerDown(serdesPowerDown), .anRestart(anRestart), .linkStatus(linkStatus)
);

// >>> mdio_station.sv
// MDIO management station model driving clause 22 frames.
// Assumes the bench resolves the shared data wire with a pull-up.
`timescale 1ns/1ps
`include "sgmii_ctrl_status_regs.svh"
module mdio_station (
  input  wire logic clk,
  input  wire logic mdioWire,
  output logic      mdc,
  output logic      stOe,
  output logic      stBit
);
  initial begin
    mdc = 1'b0;
    stOe = 1'b0;
    stBit = 1'b1;
  end
  // ========================================================================
  // One bit: 8 clk low, 8 clk high; wire sampled at the rise
  task automatic bitCycle(input logic drv, input logic val, output logic smp);
    @(negedge clk);
    mdc = 1'b0;
    stOe = drv;
    stBit = val;
    repeat (8) @(negedge clk);
    smp = mdioWire;
    mdc = 1'b1;
    repeat (7) @(negedge clk);
  endtask
  // Whole frame; station releases the wire from turnaround on reads
  task automatic xfer(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
                      input logic [15:0] wd, output logic [15:0] rd);
    logic [31:0] fr;
    logic        s;
    fr = {2'b01, op, pa, ra, 2'b10, wd};
    for (int i = 0; i < 4; i++) bitCycle(1'b1, 1'b1, s);
    for (int i = 31; i >= 0; i--) begin
      bitCycle((op == `MDIO_OP_WRITE) || (i > 17), fr[i], s);
      if (i < 16) rd[i] = s;
    end
    @(negedge clk);
    mdc = 1'b0;
    stOe = 1'b0;
    repeat (8) @(negedge clk);
  endtask
endmodule // mdio_station

// >>> sgmii_ctrl_status_regs_tb.sv
// Self-checking bench for the SGMII management register bank.
// Assumes a transceiver build at address 3, a ten-bit embedded-MAC build at 4.
`timescale 1ns/1ps
`include "sgmii_ctrl_status_regs.svh"
module sgmii_ctrl_status_regs_tb;
  logic                  clk = 1'b0;
  logic                  reset_n = 1'b0;
  logic                  softReset = 1'b0;
  logic                  clkLocked = 1'b1;
  sgmii_pkg::link_in_t   linkIn = 2'h3;
  sgmii_pkg::ctrl_bits_t ctrlOut, tbiCtrl;
  logic                  mdc, stOe, stBit, mdioWire, mOut, mOe, tOut, tOe;
  logic                  serdesPowerDown, tbiPd, anRestart, tbiRestart, linkStatus;
  int                    err_count = 0;
  int                    total_checks = 0;
  int                    pulses = 0;
  logic [15:0]           rv;
  always #12.5 clk = ~clk;
  assign mdioWire = mOe ? mOut : (tOe ? tOut : (stOe ? stBit : 1'b1));
  always @(negedge clk) if (anRestart === 1'b1) pulses++;
  mdio_station station (.clk(clk), .mdioWire(mdioWire), .mdc(mdc), .stOe(stOe), .stBit(stBit));
  sgmii_ctrl_status_regs dut (
    .clk(clk), .reset_n(reset_n), .softReset(softReset), .clkLocked(clkLocked),
    .phyAddr(5'h03), .mdc(mdc), .mdioIn(mdioWire), .mdioOut(mOut), .mdioOe(mOe),
    .linkIn(linkIn), .ctrlOut(ctrlOut), .serdesPowerDown(serdesPowerDown),
    .anRestart(anRestart), .linkStatus(linkStatus));
  sgmii_ctrl_status_regs #(.PHY_BUILD(sgmii_pkg::BUILD_TBI), .EMBEDDED_MAC_MODE(1'b1)) dutTbi (
    .clk(clk), .reset_n(reset_n), .softReset(softReset), .clkLocked(clkLocked),
    .phyAddr(5'h04), .mdc(mdc), .mdioIn(mdioWire), .mdioOut(tOut), .mdioOe(tOe),
    .linkIn(linkIn), .ctrlOut(tbiCtrl), .serdesPowerDown(tbiPd),
    .anRestart(tbiRestart), .linkStatus());
  // ========================================================================
  // Tasks
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rdc(input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] exp,
                     input string what);
    station.xfer(`MDIO_OP_READ, pa, ra, 16'h0000, rv);
    if (ra == `MDIO_REG_STAT) rv[`STAT_ANCOMP_BIT] = 1'b0;
    chk(what, exp, rv);
  endtask
  task automatic wr(input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] val);
    station.xfer(`MDIO_OP_WRITE, pa, ra, val, rv);
    repeat (4) @(negedge clk);
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // ========================================================================
  // Tests
  initial begin
    repeat (16) @(negedge clk);
    reset_n = 1'b1;
    repeat (8) @(negedge clk);
    chk("ctrl out reset", 16'h0006, {12'h000, ctrlOut});
    rdc(5'h03, `MDIO_REG_CTRL, 16'h0540, "ctrl reset");
    rdc(5'h03, `MDIO_REG_STAT, 16'h01c0, "stat first");
    rdc(5'h03, `MDIO_REG_STAT, 16'h01c4, "stat second");
    wr(5'h03, `MDIO_REG_CTRL, 16'hffff);
    chk("restart pulses", 16'h0001, 16'(pulses));
    chk("ctrl out set", 16'h000f, {12'h000, ctrlOut});
    chk("serdes pd", 16'h0001, {15'h0000, serdesPowerDown});
    rdc(5'h03, `MDIO_REG_CTRL, 16'h0d60, "ctrl all ones");
    wr(5'h03, `MDIO_REG_CTRL, 16'h0000);
    rdc(5'h03, `MDIO_REG_CTRL, 16'h0940, "ctrl zeros");
    wr(5'h03, `MDIO_REG_STAT, 16'h0000);
    rdc(5'h03, `MDIO_REG_STAT, 16'h01c4, "stat after write");
    rdc(5'h03, 5'h05, 16'h0000, "unmapped");
    rdc(5'h07, `MDIO_REG_CTRL, 16'hffff, "other address");
    linkIn.syncOk = 1'b0;
    repeat (20) @(negedge clk);
    linkIn.syncOk = 1'b1;
    repeat (4) @(negedge clk);
    chk("link latched", 16'h0000, {15'h0000, linkStatus});
    rdc(5'h03, `MDIO_REG_STAT, 16'h01c0, "stat after drop");
    rdc(5'h03, `MDIO_REG_STAT, 16'h01c4, "stat recovered");
    linkIn.xcvrResetDone = 1'b0;
    rdc(5'h03, `MDIO_REG_STAT, 16'h01c0, "xcvr busy 1");
    rdc(5'h03, `MDIO_REG_STAT, 16'h01c0, "xcvr busy 2");
    linkIn.xcvrResetDone = 1'b1;
    softReset = 1'b1;
    @(negedge clk);
    softReset = 1'b0;
    repeat (4) @(negedge clk);
    chk("soft reset", 16'h0006, {11'h000, serdesPowerDown, ctrlOut});
    wr(5'h03, `MDIO_REG_CTRL, 16'h0800);
    clkLocked = 1'b0;
    @(negedge clk);
    clkLocked = 1'b1;
    repeat (4) @(negedge clk);
    rdc(5'h03, `MDIO_REG_CTRL, 16'h0540, "lock loss");
    wr(5'h04, `MDIO_REG_CTRL, 16'h0800);
    chk("tbi ctrl", 16'h0008, {11'h000, tbiPd, tbiCtrl});
    rdc(5'h04, `MDIO_REG_CTRL, 16'h0900, "tbi readback");
    results();
  end
  initial begin
    repeat (40000) @(posedge clk);
    err_count++;
    results();
  end
endmodule // sgmii_ctrl_status_regs_tb
